// >>> design/fff_fwft_fifo.sv
// Fall-through FIFO with status flags, programmable offsets and an AHB-Lite status port.
`timescale 1ns/10ps
// Function
// [R1] Mode-select pin high during reset chooses fall-through timing, else standard.
// [R2] First word into empty FIFO reaches the outputs three edges later, unrequested.
// [R3] Writer holds write enable low to capture input data each edge.
// [R4] Output-valid goes low once the first word reaches the output register.
// [R5] Almost-empty goes high once n plus two words are held.
// [R6] Half-full goes low at 131,074 words in fall-through mode.
// [R7] Almost-full goes low at 262,145 minus m words.
// [R8] Input-room goes high and blocks writes at 262,145 words.
// [R9] Reads from full release input-room, then almost-full and half-full at thresholds.
// [R10] Draining without writes, almost-empty goes low at n plus one words.
// [R11] Output-valid goes high after the last read; reads on empty are ignored.
// [R12] Output-valid passes three register stages, input-room two.
// [R13] Offset select high at reset: serial loading, both offsets 3FF.
// [R14] Offset select low at reset: parallel loading, both offsets 07F.
// [R15] Offsets are read back only through the parallel read path; the code also returns them over the AHB-Lite port.
// [R16] Offsets may be programmed and reprogrammed any time after reset.
// [R17] Parallel write stores input into the next of six offset bytes.
// [R18] Parallel read drives the next offset byte onto the outputs.
// [R19] Serial shift takes one bit per edge, empty LSB first, 36 bits.
// [R20] After the sixth offset byte the write pointer wraps to the first.
// [R21] Offset select high: enables access memory; other combinations do nothing.
module fff_fwft_fifo
  import fff_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [FFF_DATA_W-1:0] dataInBus,
  input wire logic writeEnableN,
  input wire logic readEnableN,
  input wire logic offsetAccessSelect,
  input wire logic serialLoadEnableN,
  input wire logic modeSerialIn,
  output logic [FFF_DATA_W-1:0] dataOutBus,
  output logic dataOutOe,
  output fff_flags_t statusFlags,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  ////////////////////////////////////////////////////////////////////////////
  logic fwftMode;
  logic serialMethod;
  logic [35:0] ofsVec;
  logic [35:0] next_ofsVec;
  logic [2:0] ofsWrPtr;
  logic [2:0] next_ofsWrPtr;
  logic [2:0] ofsRdPtr;
  logic [2:0] next_ofsRdPtr;
  logic [FFF_ADDR_W-1:0] wrAddr;
  logic [FFF_ADDR_W-1:0] next_wrAddr;
  logic [FFF_ADDR_W-1:0] rdAddr;
  logic [FFF_ADDR_W-1:0] next_rdAddr;
  logic wrDly;
  logic next_wrDly;
  logic pending;
  logic next_pending;
  logic [FFF_CNT_W-1:0] memCount;
  logic [FFF_CNT_W-1:0] next_memCount;
  logic [FFF_CNT_W-1:0] fill;
  logic [FFF_CNT_W-1:0] next_fill;
  logic irStage;
  logic next_irStage;
  logic [FFF_DATA_W-1:0] next_dataOutBus;
  fff_flags_t next_statusFlags;
  logic [FFF_DATA_W-1:0] memRdData;
  fff_dphase_t dphase;
  fff_dphase_t next_dphase;
  logic next_dataOutOe;
  logic [31:0] next_hrdata;
  fff_status_t statusWord;

  logic memMode;
  logic wrAccept;
  logic pop;
  logic rdIssue;
  logic ofsWrite;
  logic ofsRead;
  logic serialShift;
  logic addrPhase;
  logic [FFF_CNT_W-1:0] fwftAdd;
  logic [FFF_CNT_W-1:0] fullLimit;
  logic [FFF_CNT_W-1:0] aeLimit;
  logic [FFF_CNT_W-1:0] hfLimit;
  logic [FFF_CNT_W-1:0] afLimit;
  logic isFull;
  logic aeHigh;
  logic hfReached;
  logic afReached;

  ////////////////////////////////////////////////////////////////////////////
  // Pin decode.
  assign memMode = offsetAccessSelect;
  assign wrAccept = memMode && !writeEnableN && !isFull; // [R3] [R8] [R21]
  assign pop = memMode && !readEnableN && !statusFlags.outputValidN; // [R11] [R21]
  // A fetch is only started when the output word will be free as the data lands.
  assign rdIssue = (memCount != '0) && !pending && (statusFlags.outputValidN || pop);
  assign ofsWrite = !memMode && !writeEnableN && readEnableN && serialLoadEnableN
                    && !serialMethod; // [R17]
  assign ofsRead = !memMode && writeEnableN && !readEnableN && serialLoadEnableN; // [R15] [R18]
  assign serialShift = !memMode && writeEnableN && readEnableN && !serialLoadEnableN
                       && serialMethod; // [R19]

  // Fall-through mode counts the output register as one more word.
  assign fwftAdd = {{(FFF_CNT_W-1){1'b0}}, fwftMode};
  assign fullLimit = FFF_DEPTH + fwftAdd;
  assign aeLimit = {1'b0, ofsVec[17:0]} + fwftAdd;
  assign hfLimit = FFF_HALF_STD + fwftAdd;
  assign afLimit = FFF_DEPTH - {1'b0, ofsVec[35:18]} + fwftAdd;
  assign isFull = fill >= fullLimit; // [R8]
  assign aeHigh = fill > aeLimit; // [R5] [R10]
  assign hfReached = fill >= hfLimit; // [R6]
  assign afReached = fill >= afLimit; // [R7]

  function automatic logic [FFF_DATA_W-1:0] ofsByte(input logic [35:0] v,
                                                    input logic [2:0] idx);
    logic [17:0] w;
    w = (idx >= 3'h3) ? v[35:18] : v[17:0];
    case (idx)
      3'h0, 3'h3: ofsByte = {1'b0, w[7:0]};
      3'h1, 3'h4: ofsByte = {1'b0, w[15:8]};
      default: ofsByte = {7'h00, w[17:16]};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Offset registers; serial and parallel loading share one 36-bit image.
  always_comb begin
    next_ofsVec = ofsVec;
    next_ofsWrPtr = ofsWrPtr;
    next_ofsRdPtr = ofsRdPtr;
    if (serialShift) begin
      next_ofsVec = {modeSerialIn, ofsVec[35:1]}; // [R19] [R16]
    end else if (ofsWrite) begin
      case (ofsWrPtr)
        3'h0: next_ofsVec[7:0] = dataInBus[7:0]; // [R17] [R16]
        3'h1: next_ofsVec[15:8] = dataInBus[7:0];
        3'h2: next_ofsVec[17:16] = dataInBus[1:0];
        3'h3: next_ofsVec[25:18] = dataInBus[7:0];
        3'h4: next_ofsVec[33:26] = dataInBus[7:0];
        default: next_ofsVec[35:34] = dataInBus[1:0];
      endcase
      next_ofsWrPtr = (ofsWrPtr == FFF_OFS_LAST) ? 3'h0 : ofsWrPtr + 3'h1; // [R20]
    end
    if (ofsRead) begin
      next_ofsRdPtr = (ofsRdPtr == FFF_OFS_LAST) ? 3'h0 : ofsRdPtr + 3'h1; // [R18]
    end
  end

  // Straps are caught by the clocked reset, so their values are whatever the pins hold last.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      fwftMode <= modeSerialIn; // [R1]
      serialMethod <= offsetAccessSelect;
      ofsVec <= offsetAccessSelect ? {FFF_OFS_DEF_SERIAL, FFF_OFS_DEF_SERIAL}
                                   : {FFF_OFS_DEF_PARALLEL, FFF_OFS_DEF_PARALLEL}; // [R13] [R14]
      ofsWrPtr <= 3'h0;
      ofsRdPtr <= 3'h0;
    end else begin
      ofsVec <= next_ofsVec;
      ofsWrPtr <= next_ofsWrPtr;
      ofsRdPtr <= next_ofsRdPtr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data path and flags.
  always_comb begin
    next_wrAddr = wrAddr;
    next_rdAddr = rdAddr;
    next_wrDly = wrAccept;
    next_pending = rdIssue;
    next_memCount = memCount;
    next_fill = fill;
    next_dataOutBus = dataOutBus;
    next_statusFlags = statusFlags;
    if (wrAccept) begin
      next_wrAddr = wrAddr + 18'h00001;
    end
    if (rdIssue) begin
      next_rdAddr = rdAddr + 18'h00001;
    end
    // The write is made visible to the fetch one edge late; stage one of the valid path.
    case ({wrDly, rdIssue})
      2'b10: next_memCount = memCount + 19'h00001; // [R12]
      2'b01: next_memCount = memCount - 19'h00001;
      default: next_memCount = memCount;
    endcase
    case ({wrAccept, pop})
      2'b10: next_fill = fill + 19'h00001;
      2'b01: next_fill = fill - 19'h00001; // [R9]
      default: next_fill = fill;
    endcase
    if (pending) begin
      next_dataOutBus = memRdData; // [R2]
      next_statusFlags.outputValidN = 1'b0; // [R4] [R12]
    end else if (pop) begin
      next_statusFlags.outputValidN = 1'b1; // [R11]
    end
    // An offset read overwrites whatever word stood on the outputs.
    if (ofsRead) begin
      next_dataOutBus = ofsByte(ofsVec, ofsRdPtr); // [R18]
    end
    next_statusFlags.almostEmptyFlag = aeHigh; // [R5] [R10]
    next_statusFlags.halfFullFlag = !hfReached; // [R6] [R9]
    next_statusFlags.almostFullFlag = !afReached; // [R7] [R9]
    next_irStage = isFull;
    next_statusFlags.inputRoomN = irStage; // [R8] [R12]
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wrAddr <= '0;
      rdAddr <= '0;
      wrDly <= 1'b0;
      pending <= 1'b0;
      memCount <= '0;
      fill <= '0;
      irStage <= 1'b0;
      dataOutBus <= '0;
      statusFlags <= FFF_FLAGS_RESET;
    end else begin
      wrAddr <= next_wrAddr;
      rdAddr <= next_rdAddr;
      wrDly <= next_wrDly;
      pending <= next_pending;
      memCount <= next_memCount;
      fill <= next_fill;
      irStage <= next_irStage;
      dataOutBus <= next_dataOutBus;
      statusFlags <= next_statusFlags;
    end
  end

  fff_mem u_mem (
    .core_clk(core_clk),
    .wrEn(wrAccept),
    .wrAddr(wrAddr),
    .wrData(dataInBus),
    .rdEn(rdIssue),
    .rdAddr(rdAddr),
    .rdData(memRdData)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, read data registered in the address phase.
  assign addrPhase = hsel && hready && htrans[1];
  assign statusWord = '{rsvdHigh: 5'h00, fill: fill, rsvdLow: 1'b0,
                        serialMethod: serialMethod, fwftMode: fwftMode, flags: statusFlags};

  always_comb begin
    next_dphase = '{valid: addrPhase, write: hwrite, addr: haddr[7:0]};
    next_hrdata = hrdata;
    next_dataOutOe = dataOutOe;
    if (addrPhase && !hwrite) begin
      case (haddr[7:0])
        FFF_REG_STATUS: next_hrdata = statusWord;
        FFF_REG_EMPTY_OFS: next_hrdata = {14'h0000, ofsVec[17:0]};
        FFF_REG_FULL_OFS: next_hrdata = {14'h0000, ofsVec[35:18]};
        FFF_REG_CTRL: next_hrdata = {31'h00000000, dataOutOe};
        default: next_hrdata = 32'h00000000;
      endcase
    end
    if (dphase.valid && dphase.write && (dphase.addr == FFF_REG_CTRL)) begin
      next_dataOutOe = hwdata[FFF_CTRL_OE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dphase <= '0;
      hrdata <= 32'h00000000;
      dataOutOe <= FFF_CTRL_OE_RESET;
      hreadyout <= 1'b1;
      hresp <= FFF_HRESP_OKAY;
    end else begin
      dphase <= next_dphase;
      hrdata <= next_hrdata;
      dataOutOe <= next_dataOutOe;
      hreadyout <= 1'b1;
      hresp <= FFF_HRESP_OKAY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_first_write;
    fwftMode && (fill == '0) && wrAccept;
  endsequence

  sequence s_fall_wait;
    statusFlags.outputValidN [*3] ##1 !statusFlags.outputValidN;
  endsequence

  a_first_fall: assert property (s_first_write |=> s_fall_wait) // [R2] [R4]
    else $error("First word did not fall through after three edges.");

  a_room_stages: assert property (statusFlags.inputRoomN == $past(isFull, 2)) // [R8] [R12]
    else $error("Input-room flag does not follow fullness by two stages.");

  a_no_overflow: assert property (fill <= fullLimit) // [R8]
    else $error("Word count passed the capacity.");

  a_almost_empty: assert property (statusFlags.almostEmptyFlag == $past(aeHigh)) // [R5] [R10]
    else $error("Almost-empty flag disagrees with the word count.");

  a_half_full: assert property (statusFlags.halfFullFlag == !$past(hfReached)) // [R6] [R9]
    else $error("Half-full flag disagrees with the word count.");

  a_almost_full: assert property (statusFlags.almostFullFlag == !$past(afReached)) // [R7] [R9]
    else $error("Almost-full flag disagrees with the word count.");

  a_empty_ignore: assert property ((fill == '0) && !wrAccept |=> fill == '0) // [R11]
    else $error("Read changed an empty FIFO.");

  a_last_read: assert property ((fill == 19'h00001) && pop && !wrAccept
                                |=> statusFlags.outputValidN && (fill == '0)) // [R11]
    else $error("Output-valid not raised after the last read.");

  a_ofs_wrap: assert property (ofsWrite && (ofsWrPtr == FFF_OFS_LAST) |=> ofsWrPtr == 3'h0) // [R20]
    else $error("Offset write pointer did not wrap.");

  a_serial_shift: assert property (serialShift |=> ofsVec[35] == $past(modeSerialIn)) // [R19]
    else $error("Serial bit not shifted in.");

  a_ofs_read: assert property (ofsRead ##1 !pending |-> dataOutBus == ofsByte($past(ofsVec),
                               $past(ofsRdPtr))) // [R18] [R15]
    else $error("Offset byte not driven on the outputs.");

  a_ofs_default: assert property ($rose(rst_b) |-> ofsVec[17:0] == ($past(offsetAccessSelect)
                                  ? FFF_OFS_DEF_SERIAL : FFF_OFS_DEF_PARALLEL)) // [R13] [R14]
    else $error("Default offset wrong after reset.");

endmodule

// >>> design/fff_pkg.sv
// Shared constants and carrier types for the fall-through FIFO block.
package fff_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int FFF_DATA_W = 9;
  localparam int FFF_ADDR_W = 18;
  localparam int FFF_CNT_W = 19;
  localparam int FFF_OFS_W = 18;
  localparam int FFF_MEM_WORDS = 262144;
  localparam int FFF_SERIAL_BITS = 36;

  // Words held by the memory array alone; fall-through mode adds the output word.
  localparam logic [18:0] FFF_DEPTH = 19'h40000;
  // Half-full boundary for standard timing; fall-through adds one.
  localparam logic [18:0] FFF_HALF_STD = 19'h20001;

  localparam logic [17:0] FFF_OFS_DEF_SERIAL = 18'h003ff;
  localparam logic [17:0] FFF_OFS_DEF_PARALLEL = 18'h0007f;
  localparam logic [2:0] FFF_OFS_LAST = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] FFF_REG_STATUS = 8'h00;
  localparam logic [7:0] FFF_REG_EMPTY_OFS = 8'h04;
  localparam logic [7:0] FFF_REG_FULL_OFS = 8'h08;
  localparam logic [7:0] FFF_REG_CTRL = 8'h0c;
  localparam int FFF_CTRL_OE_BIT = 0;
  localparam logic FFF_CTRL_OE_RESET = 1'b1;
  localparam logic FFF_HRESP_OKAY = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic inputRoomN;
    logic almostFullFlag;
    logic halfFullFlag;
    logic almostEmptyFlag;
    logic outputValidN;
  } fff_flags_t;

  // Empty FIFO: room available, not almost full, not half full, almost empty, no word.
  localparam fff_flags_t FFF_FLAGS_RESET = 5'h0d;

  typedef struct packed {
    logic [4:0] rsvdHigh;
    logic [18:0] fill;
    logic rsvdLow;
    logic serialMethod;
    logic fwftMode;
    fff_flags_t flags;
  } fff_status_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } fff_dphase_t;

endpackage

// >>> design/fff_mem.sv
// Word store of the FIFO with a registered read port.
`timescale 1ns/10ps
module fff_mem
  import fff_pkg::*;
(
  input wire logic core_clk,
  input wire logic wrEn,
  input wire logic [FFF_ADDR_W-1:0] wrAddr,
  input wire logic [FFF_DATA_W-1:0] wrData,
  input wire logic rdEn,
  input wire logic [FFF_ADDR_W-1:0] rdAddr,
  output logic [FFF_DATA_W-1:0] rdData
);

  ////////////////////////////////////////////////////////////////////////////
  logic [FFF_DATA_W-1:0] store [0:FFF_MEM_WORDS-1];

  // The caller never reads a location in the cycle it is written, so no bypass is needed.
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
    if (rdEn) begin
      rdData <= store[rdAddr];
    end
  end

endmodule

// >>> bench/fff_host_model.sv
// Host writer and reader model driving the FIFO's pin-level controls.
`timescale 1ns/10ps
module fff_host_model
  import fff_pkg::*;
(
  output logic [FFF_DATA_W-1:0] dataInBus,
  output logic writeEnableN,
  output logic readEnableN,
  output logic offsetAccessSelect,
  output logic serialLoadEnableN,
  output logic modeSerialIn,
  input wire logic core_clk
);
  ////////////////////////////////////////////////////////////
  initial begin
    dataInBus = 9'h000;
    {offsetAccessSelect, writeEnableN, readEnableN, serialLoadEnableN} = 4'hf;
    modeSerialIn = 1'h1;
  end

  ////////////////////////////////////////////////////////////
  // Control order is select, write, read, serial enable; the setting is taken at the next edge.
  task automatic drive(input logic [3:0] ctl, input logic [FFF_DATA_W-1:0] d, input logic si);
    @(posedge core_clk);
    {offsetAccessSelect, writeEnableN, readEnableN, serialLoadEnableN} <= ctl;
    dataInBus <= d;
    modeSerialIn <= si;
  endtask

  // Controls go high and the data and serial-in lines flip to the inverse of their last value, so stale data never looks held.
  task automatic idle();
    drive(4'hf, ~dataInBus, ~modeSerialIn);
  endtask
endmodule

// >>> bench/tb_fall_through_fifo_flags_offsets.sv
// Self-checking testbench for the fall-through FIFO flags and offset controls.
`timescale 1ns/10ps
module tb_fall_through_fifo_flags_offsets
  import fff_pkg::*;
;
  ////////////////////////////////////////////////////////////
  localparam logic [3:0] ctlMemWr = 4'hb;
  localparam logic [3:0] ctlMemRd = 4'hd;
  localparam logic [3:0] ctlOfsWr = 4'h3;
  localparam logic [3:0] ctlOfsRd = 4'h5;
  localparam logic [3:0] ctlShift = 4'h6;
  // Serial image: full offset 20005 above empty offset 00003.
  localparam logic [35:0] serialImage = 36'h800140003;
  logic core_clk = 1'h0;
  logic rst_b = 1'h0;
  logic [FFF_DATA_W-1:0] dataInBus;
  logic [FFF_DATA_W-1:0] dataOutBus;
  logic writeEnableN;
  logic readEnableN;
  logic offsetAccessSelect;
  logic serialLoadEnableN;
  logic modeSerialIn;
  logic dataOutOe;
  fff_flags_t statusFlags;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [FFF_DATA_W-1:0] byteTab [7] = '{9'h055, 9'h000, 9'h000, 9'h034, 9'h012, 9'h003, 9'h002};
  logic [FFF_DATA_W-1:0] words [4] = '{9'h101, 9'h0a2, 9'h1c3, 9'h044};
  int n_errors = 0;
  int checked = 0;

  always #2.5 core_clk = ~core_clk;

  fff_host_model fff_host_model_i (
    .dataInBus(dataInBus), .writeEnableN(writeEnableN), .readEnableN(readEnableN),
    .offsetAccessSelect(offsetAccessSelect), .serialLoadEnableN(serialLoadEnableN),
    .modeSerialIn(modeSerialIn), .core_clk(core_clk));

  fff_fwft_fifo fff_fwft_fifo_i (
    .core_clk(core_clk), .rst_b(rst_b), .dataInBus(dataInBus),
    .writeEnableN(writeEnableN), .readEnableN(readEnableN),
    .offsetAccessSelect(offsetAccessSelect), .serialLoadEnableN(serialLoadEnableN),
    .modeSerialIn(modeSerialIn), .dataOutBus(dataOutBus), .dataOutOe(dataOutOe),
    .statusFlags(statusFlags), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A slave that never answers must not hang the run.
  task automatic waitReady();
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      if (hreadyout === 1'h1) return;
    end
    n_errors++;
    $display("[ERR] hready expected 1 seen timeout");
    give_verdict();
  endtask

  task automatic ahbXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rdat);
    @(posedge core_clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    waitReady();
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
    rdat = hrdata;
    check("hresp", 32'(hresp), 32'(FFF_HRESP_OKAY));
  endtask

  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    ahbXfer(1'h0, a, 32'h0, v);
    check(what, v, exp);
  endtask

  task automatic ahbWr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    ahbXfer(1'h1, a, d, v);
  endtask

  task automatic doReset(input logic fwft, input logic sel);
    @(posedge core_clk);
    rst_b <= 1'h0;
    fff_host_model_i.drive({sel, 3'h7}, 9'h000, fwft);
    repeat (2) @(posedge core_clk);
    rst_b <= 1'h1;
    fff_host_model_i.idle();
  endtask

  task automatic memOp(input logic [3:0] ctl, input logic [FFF_DATA_W-1:0] d);
    fff_host_model_i.drive(ctl, d, 1'h0);
    fff_host_model_i.idle();
    repeat (4) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    doReset(1'h1, 1'h1);
    check("oe", 32'(dataOutOe), 32'(FFF_CTRL_OE_RESET));
    rdChk("status", FFF_REG_STATUS, 32'h6d);
    rdChk("emptyOfs", FFF_REG_EMPTY_OFS, 32'h3ff);
    rdChk("fullOfs", FFF_REG_FULL_OFS, 32'h3ff);
    for (int i = 0; i < FFF_SERIAL_BITS; i++) begin
      fff_host_model_i.drive(ctlShift, 9'h000, serialImage[i]);
    end
    // In serial method a parallel write must leave the offsets alone.
    fff_host_model_i.drive(ctlOfsWr, 9'h0aa, 1'h0);
    memOp(ctlOfsRd, 9'h000);
    check("ofsByte", 32'(dataOutBus), 32'h003);
    rdChk("emptyOfs", FFF_REG_EMPTY_OFS, 32'h3);
    rdChk("fullOfs", FFF_REG_FULL_OFS, 32'h20005);
    ahbWr(FFF_REG_CTRL, 32'h0);
    repeat (2) @(posedge core_clk);
    check("oe", 32'(dataOutOe), 32'h0);
    rdChk("ctrl", FFF_REG_CTRL, 32'h0);
    ahbWr(FFF_REG_STATUS, 32'hffffffff);
    rdChk("status", FFF_REG_STATUS, 32'h6d);
    rdChk("unmapped", 8'h10, 32'h0);
    $display("test serial offsets done");

    doReset(1'h1, 1'h0);
    rdChk("status", FFF_REG_STATUS, 32'h2d);
    rdChk("emptyOfs", FFF_REG_EMPTY_OFS, 32'h7f);
    rdChk("fullOfs", FFF_REG_FULL_OFS, 32'h7f);
    for (int i = 0; i < 7; i++) begin
      fff_host_model_i.drive(ctlOfsWr, byteTab[i], 1'h0);
    end
    fff_host_model_i.drive(4'h1, 9'h1ee, 1'h0);
    fff_host_model_i.drive(4'h7, 9'h1dd, 1'h0);
    fff_host_model_i.idle();
    rdChk("emptyOfs", FFF_REG_EMPTY_OFS, 32'h2);
    rdChk("fullOfs", FFF_REG_FULL_OFS, 32'h31234);
    for (int i = 0; i < 7; i++) begin
      memOp(ctlOfsRd, 9'h000);
      check("ofsByte", 32'(dataOutBus), 32'((i % 6 == 0) ? 9'h002 : byteTab[i]));
    end
    $display("test parallel offsets done");

    fff_host_model_i.drive(ctlMemWr, words[0], 1'h0);
    fff_host_model_i.idle();
    repeat (2) @(posedge core_clk);
    #1;
    check("outValidN", 32'(statusFlags.outputValidN), 32'h1);
    @(posedge core_clk);
    #1;
    check("outValidN", 32'(statusFlags.outputValidN), 32'h0);
    check("dataOut", 32'(dataOutBus), 32'(words[0]));
    for (int i = 1; i < 4; i++) begin
      fff_host_model_i.drive(ctlMemWr, words[i], 1'h0);
      if (i == 2) begin
        memOp(4'hf, 9'h000);
        check("almostEmpty", 32'(statusFlags.almostEmptyFlag), 32'h0);
      end
    end
    memOp(4'hf, 9'h000);
    check("almostEmpty", 32'(statusFlags.almostEmptyFlag), 32'h1);
    rdChk("status", FFF_REG_STATUS, 32'h42e);
    for (int i = 1; i < 5; i++) begin
      memOp(ctlMemRd, 9'h000);
      if (i < 4) begin
        check("dataOut", 32'(dataOutBus), 32'(words[i]));
      end
      if (i == 1) begin
        check("almostEmpty", 32'(statusFlags.almostEmptyFlag), 32'h0);
      end
    end
    check("flags", 32'(statusFlags), 32'(FFF_FLAGS_RESET));
    memOp(ctlMemRd, 9'h000);
    check("dataOut", 32'(dataOutBus), 32'(words[3]));
    rdChk("status", FFF_REG_STATUS, 32'h2d);
    $display("test fall-through data done");

    doReset(1'h0, 1'h1);
    rdChk("status", FFF_REG_STATUS, 32'h4d);
    $display("test standard mode strap done");
    give_verdict();
  end
endmodule
